// File: rtl/drm_ram.sv
`timescale 1ns/1ps
`include "drm_regs.svh"

module drm_ram
  import drm_pkg::*;
#(
  parameter int SW     = `DRM_SMALL_W,
  parameter int SDEPTH = `DRM_SMALL_DEPTH,
  parameter int SAW    = `DRM_SMALL_AW,
  parameter int LW     = `DRM_LARGE_W,
  parameter int LANES  = `DRM_LARGE_LANES,
  parameter int LDEPTH = `DRM_LARGE_DEPTH,
  parameter int LAW    = `DRM_LARGE_AW
) (
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic         BLK_CLK_A,
  input  wire logic         BLK_CLK_B,
  input  wire logic         IN_CLR,
  input  wire logic         OUT_CLR,
  input  wire drm_clk_sel_t WR_CLK_SEL,
  input  wire drm_clk_sel_t RADDR_CLK_SEL,
  input  wire drm_clk_sel_t RDEN_CLK_SEL,
  input  wire drm_clk_sel_t OUT_CLK_SEL,
  input  wire logic         OUT_BYPASS,
  input  wire drm_side_t    WR_SIDE,
  input  wire logic [SW-1:0]    LEFT_DIN,
  input  wire logic [SW-1:0]    RIGHT_DIN,
  input  wire logic             WREN,
  input  wire logic [SAW-1:0]   WADDR,
  input  wire logic             RDEN,
  input  wire logic [SAW-1:0]   RADDR,
  output logic      [SW-1:0]    LEFT_DOUT,
  output logic      [SW-1:0]    RIGHT_DOUT,
  input  wire logic [LAW-1:0]   PA_ADDR,
  input  wire logic             PA_WE,
  input  wire logic [LANES-1:0] PA_BE,
  input  wire logic [LW-1:0]    PA_DIN,
  output logic      [LW-1:0]    PA_DOUT,
  input  wire logic [LAW-1:0]   PB_ADDR,
  input  wire logic             PB_WE,
  input  wire logic [LANES-1:0] PB_BE,
  input  wire logic [LW-1:0]    PB_DIN,
  output logic      [LW-1:0]    PB_DOUT
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic sel_tick(drm_clk_sel_t s, logic ta, logic tb);
    return (s == DRM_SEL_B) ? tb : ta;
  endfunction

  function automatic logic [LW-1:0] lane_merge(logic [LW-1:0] old_w, logic [LW-1:0] new_w,
                                              logic [LANES-1:0] be);
    logic [LW-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        res[i*`DRM_LANE_W +: `DRM_LANE_W] = new_w[i*`DRM_LANE_W +: `DRM_LANE_W];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Block clock edges
  // ----------------------------------------
  // Block clocks come from fabric logic on CLK, so an edge is a rising level
  logic clk_a_q_r;
  logic clk_b_q_r;
  logic tick_a;
  logic tick_b;
  logic wr_tick;
  logic raddr_tick;
  logic rden_tick;
  logic out_tick;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clk_a_q_r <= 1'b0;
      clk_b_q_r <= 1'b0;
    end else begin
      clk_a_q_r <= BLK_CLK_A;
      clk_b_q_r <= BLK_CLK_B;
    end
  end

  always_comb begin
    tick_a     = BLK_CLK_A & ~clk_a_q_r;
    tick_b     = BLK_CLK_B & ~clk_b_q_r;
    wr_tick    = sel_tick(WR_CLK_SEL, tick_a, tick_b);
    raddr_tick = sel_tick(RADDR_CLK_SEL, tick_a, tick_b);
    rden_tick  = sel_tick(RDEN_CLK_SEL, tick_a, tick_b);
    out_tick   = sel_tick(OUT_CLK_SEL, tick_a, tick_b);
  end

  // ----------------------------------------
  // Small block registers
  // ----------------------------------------
  logic [SW-1:0]  smem [SDEPTH];
  logic [SW-1:0]  smem_nxt [SDEPTH];
  logic           wren_r,  wren_nxt;
  logic [SW-1:0]  wdata_r, wdata_nxt;
  logic [SAW-1:0] waddr_r, waddr_nxt;
  logic [SAW-1:0] raddr_r, raddr_nxt;
  logic           rden_r,  rden_nxt;
  logic [SW-1:0]  rword_r, rword_nxt;
  logic [SW-1:0]  outq_r,  outq_nxt;
  logic [SW-1:0]  dout_r,  dout_nxt;

  always_comb begin
    smem_nxt  = smem;
    wren_nxt  = wren_r;
    wdata_nxt = wdata_r;
    waddr_nxt = waddr_r;
    raddr_nxt = raddr_r;
    rden_nxt  = rden_r;
    rword_nxt = rword_r;
    outq_nxt  = outq_r;
    // Store uses the word captured on the previous write tick
    if (wr_tick && wren_r) begin
      smem_nxt[waddr_r] = wdata_r;
    end
    // Input registers are never bypassed, only cleared
    if (IN_CLR) begin
      wren_nxt  = 1'b0;
      wdata_nxt = '0;
      waddr_nxt = '0;
    end else if (wr_tick) begin
      wren_nxt  = WREN;
      wdata_nxt = (WR_SIDE == DRM_SIDE_RIGHT) ? RIGHT_DIN : LEFT_DIN;
      waddr_nxt = WADDR;
    end
    if (IN_CLR) begin
      raddr_nxt = '0;
    end else if (raddr_tick) begin
      raddr_nxt = RADDR;
    end
    // Read strobe register has no clear path
    if (rden_tick) begin
      rden_nxt = RDEN;
    end
    if (rden_r) begin
      rword_nxt = smem[raddr_r];
    end
    if (OUT_CLR) begin
      outq_nxt = '0;
    end else if (out_tick) begin
      outq_nxt = rword_r;
    end
    // Extra stage keeps the pins on a flop even in bypass
    dout_nxt = OUT_BYPASS ? rword_r : outq_r;
  end

  // Storage carries no reset; contents are undefined until written
  always_ff @(posedge CLK) begin
    smem <= smem_nxt;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wren_r  <= 1'b0;
      wdata_r <= '0;
      waddr_r <= '0;
      raddr_r <= '0;
      rden_r  <= 1'b0;
      rword_r <= '0;
      outq_r  <= '0;
      dout_r  <= '0;
    end else begin
      wren_r  <= wren_nxt;
      wdata_r <= wdata_nxt;
      waddr_r <= waddr_nxt;
      raddr_r <= raddr_nxt;
      rden_r  <= rden_nxt;
      rword_r <= rword_nxt;
      outq_r  <= outq_nxt;
      dout_r  <= dout_nxt;
    end
  end

  // Same word reaches both neighbouring clusters
  assign LEFT_DOUT  = dout_r;
  assign RIGHT_DOUT = dout_r;

  // ----------------------------------------
  // Large block, two 72-bit ports
  // ----------------------------------------
  logic [LW-1:0] lmem [LDEPTH];
  logic [LW-1:0] lmem_nxt [LDEPTH];
  logic [LW-1:0] pa_dout_r, pa_dout_nxt;
  logic [LW-1:0] pb_dout_r, pb_dout_nxt;

  always_comb begin
    lmem_nxt    = lmem;
    pa_dout_nxt = pa_dout_r;
    pb_dout_nxt = pb_dout_r;
    // Address, select and lane mask are taken as one group per port
    if (PA_WE) begin
      lmem_nxt[PA_ADDR] = lane_merge(lmem[PA_ADDR], PA_DIN, PA_BE);
    end else begin
      pa_dout_nxt = lmem[PA_ADDR];
    end
    // Port B applied last, so its enabled lanes win a same-address collision
    if (PB_WE) begin
      lmem_nxt[PB_ADDR] = lane_merge(lmem_nxt[PB_ADDR], PB_DIN, PB_BE);
    end else begin
      pb_dout_nxt = lmem[PB_ADDR];
    end
  end

  always_ff @(posedge CLK) begin
    lmem <= lmem_nxt;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pa_dout_r <= '0;
      pb_dout_r <= '0;
    end else begin
      pa_dout_r <= pa_dout_nxt;
      pb_dout_r <= pb_dout_nxt;
    end
  end

  assign PA_DOUT = pa_dout_r;
  assign PB_DOUT = pb_dout_r;

endmodule

// File: inc/drm_regs.svh
// Functional notes
// - Write strobe, write data and write address registers share one selected block clock.
// - Read address, read strobe and output registers each pick either block clock.
// - Only the output register can be bypassed; input registers always stay in path.
// - Every memory register has a clear, except the read strobe, read word and final pin registers.
// - Ten direct inputs from each side cluster, ten outputs to both clusters.
// - Large RAM has 72 data inputs and 72 outputs on each port.
`ifndef DRM_REGS_SVH
`define DRM_REGS_SVH

// ----------------------------------------
// Small block geometry
// ----------------------------------------
`define DRM_SMALL_W      10
`define DRM_SMALL_DEPTH  32
`define DRM_SMALL_AW     5

// ----------------------------------------
// Large block geometry
// ----------------------------------------
`define DRM_LARGE_W      72
`define DRM_LANE_W       8
`define DRM_LARGE_LANES  9
`define DRM_LARGE_DEPTH  64
`define DRM_LARGE_AW     6

`endif

// File: inc/drm_pkg.sv
package drm_pkg;

  // Which of the two block clocks drives a register group
  typedef enum logic {
    DRM_SEL_A = 1'b0,
    DRM_SEL_B = 1'b1
  } drm_clk_sel_t;

  // Which neighbouring cluster feeds the write data
  typedef enum logic {
    DRM_SIDE_LEFT  = 1'b0,
    DRM_SIDE_RIGHT = 1'b1
  } drm_side_t;

endpackage

// File: verification/drm_ram_asserts.sv
`timescale 1ns/1ps
module drm_ram_asserts #(parameter int SW = 10, LW = 72, LANES = 9, LAW = 6) (
  input wire logic             CLK,
  input wire logic             SYS_RST,
  input wire logic             OUT_CLR,
  input wire logic             OUT_BYPASS,
  input wire logic [SW-1:0]    LEFT_DOUT,
  input wire logic [SW-1:0]    RIGHT_DOUT,
  input wire logic [LAW-1:0]   PA_ADDR,
  input wire logic             PA_WE,
  input wire logic [LANES-1:0] PA_BE,
  input wire logic [LW-1:0]    PA_DIN,
  input wire logic [LW-1:0]    PA_DOUT,
  input wire logic [LAW-1:0]   PB_ADDR,
  input wire logic             PB_WE,
  input wire logic [LANES-1:0] PB_BE,
  input wire logic [LW-1:0]    PB_DIN,
  input wire logic [LW-1:0]    PB_DOUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  chk_dout_pair: assert property (LEFT_DOUT == RIGHT_DOUT)
    else $error("cluster outputs differ");
  chk_rst_quiet: assert property ($fell(SYS_RST) |-> PA_DOUT == '0 && PB_DOUT == '0 && LEFT_DOUT == '0)
    else $error("outputs not quiet after reset");
  chk_outclr_zero: assert property (OUT_CLR && !OUT_BYPASS ##1 !OUT_BYPASS |=> LEFT_DOUT == '0)
    else $error("output clear ignored");
  chk_pa_hold: assert property (PA_WE |=> $stable(PA_DOUT))
    else $error("port A output moved on write");
  chk_pb_hold: assert property (PB_WE |=> $stable(PB_DOUT))
    else $error("port B output moved on write");
  chk_pa_read: assert property (
    PA_WE && &PA_BE && !(PB_WE && PB_ADDR == PA_ADDR) ##1
    !PA_WE && PA_ADDR == $past(PA_ADDR) |=> PA_DOUT == $past(PA_DIN, 2))
    else $error("port A readback wrong");
  chk_pb_read: assert property (
    PB_WE && &PB_BE ##1
    !PB_WE && PB_ADDR == $past(PB_ADDR) |=> PB_DOUT == $past(PB_DIN, 2))
    else $error("port B readback wrong");
  chk_pb_wins: assert property (
    PA_WE && PB_WE && PA_ADDR == PB_ADDR && &PB_BE ##1
    !PA_WE && PA_ADDR == $past(PA_ADDR) |=> PA_DOUT == $past(PB_DIN, 2))
    else $error("port B did not win collision");
  cover property (PA_WE && PB_WE && PA_ADDR == PB_ADDR);
  cover property (OUT_CLR && !OUT_BYPASS);
  cover property (OUT_BYPASS && LEFT_DOUT != '0);
endmodule
bind drm_ram drm_ram_asserts #(.SW(SW), .LW(LW), .LANES(LANES), .LAW(LAW)) chk (.*);

// File: verification/drm_fab.sv
`timescale 1ns/1ps
// --
// Cluster clock lines: A fast, B slow
// --
module drm_fab (
  input  wire logic clk,
  input  wire logic rst,
  output logic      cka,
  output logic      ckb
);
  logic [1:0] cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  end
  // Low at release so no false tick
  assign cka = cnt_r[0];
  assign ckb = cnt_r[1];
endmodule

// File: verification/drm_ram_test.sv
`timescale 1ns/1ps
module drm_ram_test;
  import drm_pkg::*;
  logic CLK = 0, SYS_RST = 1, BLK_CLK_A, BLK_CLK_B, IN_CLR = 0, OUT_CLR = 0, OUT_BYPASS = 0;
  logic WREN = 0, RDEN = 0, PA_WE = 0, PB_WE = 0;
  drm_clk_sel_t WR_CLK_SEL = DRM_SEL_A, RADDR_CLK_SEL = DRM_SEL_A, RDEN_CLK_SEL = DRM_SEL_A, OUT_CLK_SEL = DRM_SEL_A;
  drm_side_t WR_SIDE = DRM_SIDE_LEFT;
  logic [9:0] LEFT_DIN = 0, RIGHT_DIN = 0, LEFT_DOUT, RIGHT_DOUT;
  logic [4:0] WADDR = 0, RADDR = 0;
  logic [5:0] PA_ADDR = 0, PB_ADDR = 0, cfg;
  logic [8:0] PA_BE = 0, PB_BE = 0;
  logic [71:0] PA_DIN = 0, PB_DIN = 0, PA_DOUT, PB_DOUT, want;
  integer seed = 32'h72e3, err_total = 0, checks_done = 0, i;
  drm_ram uut (.*);
  drm_fab fab (.clk(CLK), .rst(SYS_RST), .cka(BLK_CLK_A), .ckb(BLK_CLK_B));
  initial forever #5 CLK = ~CLK;
  task chk(input logic [71:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  function logic [71:0] merge(input logic [71:0] old, nw, input logic [8:0] be);
    for (int k = 0; k < 9; k++) if (be[k]) old[8*k+:8] = nw[8*k+:8];
    return old;
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Run far beyond need counts as a hang
  initial begin
    #200000;
    err_total++;
    close_out;
  end
  initial begin
    step(3);
    SYS_RST = 0;
    IN_CLR = 1;
    step(2);
    IN_CLR = 0;
    for (i = 0; i < 4; i++) begin
      cfg = (i == 0) ? 6'h3F : 6'($random(seed));
      WR_CLK_SEL = drm_clk_sel_t'(cfg[0]);
      RADDR_CLK_SEL = drm_clk_sel_t'(cfg[1]);
      RDEN_CLK_SEL = drm_clk_sel_t'(cfg[2]);
      OUT_CLK_SEL = drm_clk_sel_t'(cfg[3]);
      OUT_BYPASS = cfg[4];
      WR_SIDE = drm_side_t'(cfg[5]);
      WADDR = 5'($random(seed));
      LEFT_DIN = 10'($random(seed));
      RIGHT_DIN = 10'($random(seed));
      WREN = 1;
      step(10);
      WREN = 0;
      RADDR = WADDR;
      RDEN = 1;
      // Slow clock B: up to four ticks deep
      step(16);
      RDEN = 0;
      chk(72'(LEFT_DOUT), 72'(cfg[5] ? RIGHT_DIN : LEFT_DIN), "left word");
      chk(72'(RIGHT_DOUT), 72'(cfg[5] ? RIGHT_DIN : LEFT_DIN), "right word");
    end
    OUT_BYPASS = 0;
    OUT_CLR = 1;
    step(3);
    chk(72'(LEFT_DOUT), 72'h0, "cleared word");
    OUT_CLR = 0;
    OUT_BYPASS = 1;
    WR_CLK_SEL = DRM_SEL_A;
    RADDR_CLK_SEL = DRM_SEL_A;
    RDEN_CLK_SEL = DRM_SEL_A;
    OUT_CLK_SEL = DRM_SEL_A;
    WR_SIDE = DRM_SIDE_LEFT;
    WADDR = 5'h00;
    LEFT_DIN = 10'h155;
    WREN = 1;
    step(4);
    WADDR = 5'h01;
    LEFT_DIN = 10'h2AA;
    step(4);
    WREN = 0;
    RADDR = 5'h01;
    RDEN = 1;
    step(6);
    chk(72'(LEFT_DOUT), 72'h2AA, "bypass word");
    // Clear zeroes read address but read strobe keeps reading
    IN_CLR = 1;
    WREN = 1;
    WADDR = 5'h00;
    LEFT_DIN = 10'h3FF;
    step(4);
    chk(72'(LEFT_DOUT), 72'h155, "input clear word");
    IN_CLR = 0;
    WREN = 0;
    RDEN = 0;
    $display("small block test done");
    for (i = 0; i < 20; i++) begin
      PA_ADDR = 6'($random(seed));
      PB_ADDR = PA_ADDR;
      PA_DIN = 72'({$random(seed), $random(seed), $random(seed)});
      PB_DIN = 72'({$random(seed), $random(seed), $random(seed)});
      PB_BE = (i % 4 == 0) ? 9'h1FF : 9'($random(seed));
      PA_BE = 9'h1FF;
      PA_WE = 1;
      step(1);
      PA_WE = (i % 4 == 0);
      PB_WE = 1;
      step(1);
      PA_WE = 0;
      PB_WE = 0;
      step(1);
      want = merge(PA_DIN, PB_DIN, PB_BE);
      chk(PA_DOUT, want, "port A word");
      chk(PB_DOUT, want, "port B word");
    end
    $display("large block test done");
    close_out;
  end
endmodule
